// *** rtl/cfg_cap_pkg.sv ***
package cfg_cap_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_IRQ_ADDR_LO = 8'h90;
  localparam logic [7:0] OFF_IRQ_ADDR_HI = 8'h94;
  localparam logic [7:0] OFF_IRQ_DATA = 8'h98;
  localparam logic [7:0] OFF_PD_CTRL = 8'h9c;
  localparam logic [7:0] OFF_PD_WORD = 8'ha0;
  localparam logic [7:0] OFF_VENDOR_CAP = 8'ha4;
  localparam logic [7:0] OFF_TEST_0 = 8'ha8;
  localparam logic [7:0] OFF_TEST_1 = 8'hac;
  localparam logic [7:0] OFF_REPLAY = 8'hb0;
  localparam logic [7:0] OFF_MSG_CTRL = 8'hb4;

  // ----------------------------------------------------------------
  // fixed values and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PD_CAP_ID = 8'h03;
  localparam logic [7:0] PD_NEXT_PTR = 8'ha4;
  localparam logic [7:0] VENDOR_CAP_ID = 8'h09;
  localparam logic [7:0] VENDOR_NEXT_PTR = 8'he0;
  localparam logic [15:0] VENDOR_LENGTH = 16'h0028;
  localparam logic [31:0] TEST_0_RESET = 32'h04001060;
  // printed with nine digits; the low 32 bits are kept
  localparam logic [31:0] TEST_1_RESET = 32'h04000271;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PD_START_BIT = 16;
  localparam int PD_DIR_BIT = 17;
  localparam int PD_INDEX_LSB = 18;
  localparam int RPL_ENABLE_BIT = 12;
  localparam int MSG_ENABLE_BIT = 16;
  localparam int MSG_64BIT_BIT = 23;

  // ----------------------------------------------------------------
  // eeprom transfer timing
  // ----------------------------------------------------------------
  localparam int EE_ACCESS_NS = 400;
  localparam int CLK_PERIOD_NS = 4;
  localparam int EE_ACCESS_CYC = (EE_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EE_CNT_W = 8;

  typedef struct packed {
    logic [31:0] addr;
    logic write;
    logic [31:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic [11:0] value;
    logic enable;
  } replay_cfg_t;

endpackage

// *** rtl/config_capability_registers.sv ***
// Register access over APB was decided locally.
`timescale 1ns/100ps
// Functional notes
// R01: the low interrupt address keeps bits 31:2 writable, reads zero in 1:0 and resets to zero.
// R02: the high interrupt address is a writable word reset to zero, used only when 64-bit addressing is advertised.
// R03: the product-data header reads identifier 03h and next pointer a4h.
// R04: software sets the start flag at bit 16 and the device clears it when the transfer ends; reset zero.
// R05: the direction flag at bit 17 selects read (0) or write (1); reset zero.
// R06: bits 22:18 hold the five-bit word index into the eeprom table; reset zero.
// R07: reading the product-data word returns the last word fetched; reset zero.
// R08: the written product-data word is what a write transfer stores into the table.
// R09: the vendor header reads identifier 09h and next pointer e0h.
// R10: the vendor header upper half reads 28h, the structure length.
// R11: the replay value is twelve writable bits 11:0 reset zero, bits 15:13 read zero.
// R12: with bit 12 set, the link layer uses the user replay value instead of its default.
// R13: the replay value and its enable may be replaced by values autoloaded from the eeprom after reset.
// R14: the interrupt enable at bit 16 of the message control word permits memory-write interrupts and stops the pin.
// R15: the message control word reads bit 23 as one to advertise 64-bit addresses.
// R16: software loads the data word before a write and polls the start flag before the next access.
module config_capability_registers
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic autoloadValid,
  input wire logic [12:0] autoloadReplay,
  input wire logic [31:0] eeReadWord,
  output logic [31:0] eeWriteWord,
  output logic [4:0] eeIndex,
  output logic eeWriteStrobe,
  output logic eeReadStrobe,
  input wire logic legacyIrqIn,
  output logic legacyIrqOut,
  output logic msgIrqEnable,
  output logic [63:0] msgIrqAddress,
  output logic [15:0] msgIrqData,
  output logic replayOverride,
  output logic [11:0] replayValue
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  cfg_cap_pkg::bus_req_t req;
  logic wrEn;
  logic rdEn;
  logic mapped;
  logic [31:0] rdData;

  assign req = '{addr: paddr, write: pwrite, wdata: pwdata};
  // unmapped writes must not alias onto a register through the low address byte
  assign wrEn = psel && penable && req.write && mapped;
  assign rdEn = psel && penable && !req.write;
  assign pready = 1'b1;

  always_comb
  begin
    mapped = 1'b1;
    case (req.addr[7:0])
      cfg_cap_pkg::OFF_IRQ_ADDR_LO, cfg_cap_pkg::OFF_IRQ_ADDR_HI, cfg_cap_pkg::OFF_IRQ_DATA,
      cfg_cap_pkg::OFF_PD_CTRL, cfg_cap_pkg::OFF_PD_WORD, cfg_cap_pkg::OFF_VENDOR_CAP,
      cfg_cap_pkg::OFF_TEST_0, cfg_cap_pkg::OFF_TEST_1, cfg_cap_pkg::OFF_REPLAY,
      cfg_cap_pkg::OFF_MSG_CTRL:
        mapped = (req.addr[31:8] == 24'h000000);
      default:
        mapped = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !mapped;

  // ----------------------------------------------------------------
  // interrupt message registers
  // ----------------------------------------------------------------
  logic [29:0] irqAddrLo_q;
  logic [31:0] irqAddrHi_q;
  logic [15:0] irqData_q;
  logic msgEnable_q;

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irqAddrLo_q <= 30'h00000000;
      irqAddrHi_q <= 32'h00000000;
      irqData_q <= 16'h0000;
      msgEnable_q <= 1'b0;
    end
    else if (wrEn && mapped)
    begin
      if (req.addr[7:0] == cfg_cap_pkg::OFF_IRQ_ADDR_LO)
        irqAddrLo_q <= req.wdata[31:2]; // R01
      if (req.addr[7:0] == cfg_cap_pkg::OFF_IRQ_ADDR_HI)
        irqAddrHi_q <= req.wdata; // R02
      if (req.addr[7:0] == cfg_cap_pkg::OFF_IRQ_DATA)
        irqData_q <= req.wdata[15:0];
      if (req.addr[7:0] == cfg_cap_pkg::OFF_MSG_CTRL)
        msgEnable_q <= req.wdata[cfg_cap_pkg::MSG_ENABLE_BIT]; // R14
    end
  end

  // 64-bit capability is hardwired, so the high word always joins the address
  localparam logic MSG_64BIT_CAPABLE = 1'b1;

  assign msgIrqEnable = msgEnable_q; // R14
  assign legacyIrqOut = legacyIrqIn && !msgEnable_q; // R14
  assign msgIrqAddress = {MSG_64BIT_CAPABLE ? irqAddrHi_q : 32'h00000000, irqAddrLo_q, 2'b00}; // R01 R02 R15
  assign msgIrqData = irqData_q;

  // ----------------------------------------------------------------
  // product-data port
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PD_IDLE, PD_BUSY, PD_DONE} pd_state_t;
  pd_state_t pdState_q;
  logic pdStart_q;
  logic pdDir_q;
  logic [4:0] pdIndex_q;
  logic [31:0] pdWord_q;
  logic [cfg_cap_pkg::EE_CNT_W-1:0] pdCnt_q;
  logic pdKick;
  logic pdWordWr;

  assign pdKick = wrEn && req.addr[7:0] == cfg_cap_pkg::OFF_PD_CTRL && req.wdata[cfg_cap_pkg::PD_START_BIT]
                  && pdState_q == PD_IDLE;
  assign pdWordWr = wrEn && req.addr[7:0] == cfg_cap_pkg::OFF_PD_WORD;

  // control fields are frozen while busy so the eeprom sees a stable index
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pdDir_q <= 1'b0;
      pdIndex_q <= 5'h00;
    end
    else if (wrEn && req.addr[7:0] == cfg_cap_pkg::OFF_PD_CTRL && pdState_q == PD_IDLE)
    begin
      pdDir_q <= req.wdata[cfg_cap_pkg::PD_DIR_BIT]; // R05
      pdIndex_q <= req.wdata[cfg_cap_pkg::PD_INDEX_LSB +: 5]; // R06
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pdState_q <= PD_IDLE;
      pdStart_q <= 1'b0;
      pdCnt_q <= '0;
    end
    else
    begin
      case (pdState_q)
        PD_IDLE:
          if (pdKick)
          begin
            pdState_q <= PD_BUSY; // R04
            pdStart_q <= 1'b1;
            pdCnt_q <= cfg_cap_pkg::EE_CNT_W'(cfg_cap_pkg::EE_ACCESS_CYC - 1);
          end
        PD_BUSY:
          if (pdCnt_q == '0)
            pdState_q <= PD_DONE;
          else
            pdCnt_q <= pdCnt_q - 1'b1;
        PD_DONE:
        begin
          pdState_q <= PD_IDLE;
          pdStart_q <= 1'b0; // R04
        end
        default:
          pdState_q <= PD_IDLE;
      endcase
    end
  end

  // a write of the word register during a read transfer is dropped by the fetch (R16 is software's)
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      pdWord_q <= 32'h00000000;
    else if (pdState_q == PD_DONE && !pdDir_q)
      pdWord_q <= eeReadWord; // R07
    else if (pdWordWr)
      pdWord_q <= req.wdata; // R08
  end

  assign eeIndex = pdIndex_q;
  assign eeWriteWord = pdWord_q; // R08
  assign eeWriteStrobe = pdState_q == PD_DONE && pdDir_q; // R05
  assign eeReadStrobe = pdState_q == PD_DONE && !pdDir_q; // R05

  // ----------------------------------------------------------------
  // test words and replay override
  // ----------------------------------------------------------------
  logic [31:0] test0_q;
  logic [31:0] test1_q;
  cfg_cap_pkg::replay_cfg_t replay_q;

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      test0_q <= cfg_cap_pkg::TEST_0_RESET;
      test1_q <= cfg_cap_pkg::TEST_1_RESET;
      replay_q <= '0;
    end
    else
    begin
      if (wrEn && req.addr[7:0] == cfg_cap_pkg::OFF_TEST_0)
        test0_q <= req.wdata;
      if (wrEn && req.addr[7:0] == cfg_cap_pkg::OFF_TEST_1)
        test1_q <= req.wdata;
      // a software write in the same cycle as the autoload wins
      if (wrEn && req.addr[7:0] == cfg_cap_pkg::OFF_REPLAY)
        replay_q <= '{value: req.wdata[11:0], enable: req.wdata[cfg_cap_pkg::RPL_ENABLE_BIT]}; // R11
      else if (autoloadValid)
        replay_q <= '{value: autoloadReplay[11:0], enable: autoloadReplay[12]}; // R13
    end
  end

  assign replayOverride = replay_q.enable; // R12
  assign replayValue = replay_q.value; // R12

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb
  begin
    rdData = 32'h00000000;
    case (req.addr[7:0])
      cfg_cap_pkg::OFF_IRQ_ADDR_LO: rdData = {irqAddrLo_q, 2'b00}; // R01
      cfg_cap_pkg::OFF_IRQ_ADDR_HI: rdData = irqAddrHi_q;
      cfg_cap_pkg::OFF_IRQ_DATA: rdData = {16'h0000, irqData_q};
      cfg_cap_pkg::OFF_PD_CTRL:
        rdData = {9'h000, pdIndex_q, pdDir_q, pdStart_q, cfg_cap_pkg::PD_NEXT_PTR, cfg_cap_pkg::PD_CAP_ID}; // R03
      cfg_cap_pkg::OFF_PD_WORD: rdData = pdWord_q; // R07
      cfg_cap_pkg::OFF_VENDOR_CAP:
        rdData = {cfg_cap_pkg::VENDOR_LENGTH, cfg_cap_pkg::VENDOR_NEXT_PTR, cfg_cap_pkg::VENDOR_CAP_ID}; // R09 R10
      cfg_cap_pkg::OFF_TEST_0: rdData = test0_q;
      cfg_cap_pkg::OFF_TEST_1: rdData = test1_q;
      cfg_cap_pkg::OFF_REPLAY: rdData = {19'h00000, replay_q.enable, replay_q.value}; // R11
      cfg_cap_pkg::OFF_MSG_CTRL: rdData = {8'h00, MSG_64BIT_CAPABLE, 6'h00, msgEnable_q, 16'h0000}; // R15
      default: rdData = 32'h00000000;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
      prdata <= (req.addr[31:8] == 24'h000000) ? rdData : 32'h00000000;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_addr_lo_write;
    @(posedge mclk) disable iff (sys_rst)
    wrEn && paddr == 32'h90 |=> msgIrqAddress[31:0] == {$past(pwdata[31:2]), 2'b00};
  endproperty
  a_addr_lo_write: assert property (p_addr_lo_write) else $error("low address not stored"); // R01

  property p_addr_hi_write;
    @(posedge mclk) disable iff (sys_rst)
    wrEn && paddr == 32'h94 |=> msgIrqAddress[63:32] == $past(pwdata);
  endproperty
  a_addr_hi_write: assert property (p_addr_hi_write) else $error("high address not stored"); // R02

  property p_pd_header;
    @(posedge mclk) disable iff (sys_rst)
    psel && !penable && !pwrite && paddr == 32'h9c |=> prdata[15:0] == 16'ha403;
  endproperty
  a_pd_header: assert property (p_pd_header) else $error("product header wrong"); // R03

  property p_start_clears;
    @(posedge mclk) disable iff (sys_rst)
    pdKick |=> pdStart_q ##[1:120] !pdStart_q;
  endproperty
  a_start_clears: assert property (p_start_clears) else $error("start flag not cleared"); // R04

  property p_dir_strobe;
    @(posedge mclk) disable iff (sys_rst)
    pdKick |=> ##100 (eeWriteStrobe == pdDir_q) && (eeReadStrobe == !pdDir_q);
  endproperty
  a_dir_strobe: assert property (p_dir_strobe) else $error("strobe against direction"); // R05

  property p_read_fetch;
    @(posedge mclk) disable iff (sys_rst)
    eeReadStrobe |=> pdWord_q == $past(eeReadWord);
  endproperty
  a_read_fetch: assert property (p_read_fetch) else $error("fetched word lost"); // R07

  property p_vendor_hdr;
    @(posedge mclk) disable iff (sys_rst)
    psel && !penable && !pwrite && paddr == 32'ha4 |=> prdata == 32'h0028e009;
  endproperty
  a_vendor_hdr: assert property (p_vendor_hdr) else $error("vendor header wrong"); // R09

  property p_replay_write;
    @(posedge mclk) disable iff (sys_rst)
    wrEn && paddr == 32'hb0 |=> replayValue == $past(pwdata[11:0]) && replayOverride == $past(pwdata[12]);
  endproperty
  a_replay_write: assert property (p_replay_write) else $error("replay override not stored"); // R12

  property p_legacy_gate;
    @(posedge mclk) disable iff (sys_rst)
    msgIrqEnable |-> !legacyIrqOut;
  endproperty
  a_legacy_gate: assert property (p_legacy_gate) else $error("legacy pin active with msg enable"); // R14

  property p_addr_lo_zero;
    @(posedge mclk) disable iff (sys_rst)
    psel && !penable && !pwrite && paddr == 32'h90 |=> prdata[1:0] == 2'b00;
  endproperty
  a_addr_lo_zero: assert property (p_addr_lo_zero) else $error("low address bits not zero"); // R01

  property p_pd_ctrl_reserved;
    @(posedge mclk) disable iff (sys_rst)
    psel && !penable && !pwrite && paddr == 32'h9c |=> prdata[31:23] == 9'h000;
  endproperty
  a_pd_ctrl_reserved: assert property (p_pd_ctrl_reserved) else $error("control upper bits not zero"); // R06

  property p_start_holds;
    @(posedge mclk) disable iff (sys_rst)
    pdStart_q && pdState_q != PD_DONE |=> pdStart_q;
  endproperty
  a_start_holds: assert property (p_start_holds) else $error("start flag dropped early"); // R04

  property p_fields_frozen;
    @(posedge mclk) disable iff (sys_rst)
    pdState_q != PD_IDLE |=> $stable(pdIndex_q) && $stable(pdDir_q);
  endproperty
  a_fields_frozen: assert property (p_fields_frozen) else $error("control fields moved while busy"); // R06

  property p_word_write;
    @(posedge mclk) disable iff (sys_rst)
    pdWordWr && !(pdState_q == PD_DONE && !pdDir_q) |=> eeWriteWord == $past(pwdata);
  endproperty
  a_word_write: assert property (p_word_write) else $error("written data word not stored"); // R08

  property p_replay_reserved;
    @(posedge mclk) disable iff (sys_rst)
    psel && !penable && !pwrite && paddr == 32'hb0 |=> prdata[31:13] == 19'h00000;
  endproperty
  a_replay_reserved: assert property (p_replay_reserved) else $error("replay upper bits not zero"); // R11

  property p_msg_capable;
    @(posedge mclk) disable iff (sys_rst)
    psel && !penable && !pwrite && paddr == 32'hb4 |=> prdata[23];
  endproperty
  a_msg_capable: assert property (p_msg_capable) else $error("64-bit capability bit not set"); // R15

  property p_unmapped_hold;
    @(posedge mclk) disable iff (sys_rst)
    psel && penable && pwrite && paddr[31:8] != 24'h000000 && !autoloadValid
      |=> $stable(replayValue) && $stable(replayOverride) && $stable(msgIrqAddress);
  endproperty
  a_unmapped_hold: assert property (p_unmapped_hold) else $error("unmapped write changed a register"); // R11

  property p_autoload;
    @(posedge mclk) disable iff (sys_rst)
    autoloadValid && !(wrEn && paddr[7:0] == 8'hb0)
      |=> replayValue == $past(autoloadReplay[11:0]) && replayOverride == $past(autoloadReplay[12]);
  endproperty
  a_autoload: assert property (p_autoload) else $error("autoload not applied"); // R13

  property p_word_read;
    @(posedge mclk) disable iff (sys_rst)
    rdEn && paddr == 32'ha0 |-> prdata == pdWord_q;
  endproperty
  a_word_read: assert property (p_word_read) else $error("data word read wrong"); // R07

  c_pd_read: cover property (@(posedge mclk) disable iff (sys_rst) eeReadStrobe);
  c_pd_write: cover property (@(posedge mclk) disable iff (sys_rst) eeWriteStrobe);
  c_autoload: cover property (@(posedge mclk) disable iff (sys_rst) autoloadValid);
  c_unmapped: cover property (@(posedge mclk) disable iff (sys_rst) pslverr);
  c_pd_kick: cover property (@(posedge mclk) disable iff (sys_rst) pdKick);

endmodule // config_capability_registers

// *** tb/ee_table_model.sv ***
`timescale 1ns/100ps
module ee_table_model
(
  input wire logic mclk,
  input wire logic [4:0] eeIndex,
  input wire logic [31:0] eeWriteWord,
  input wire logic eeWriteStrobe,
  input wire logic eeReadStrobe,
  output logic [31:0] eeReadWord
);
  // ----------------------------------------------------------------
  // word table behind the product-data port
  // ----------------------------------------------------------------
  logic [31:0] mem [32];
  initial
  begin
    for (int i = 0; i < 32; i++)
      mem[i] = 32'ha5c30000 + 32'(i);
  end
  always @(posedge mclk)
  begin
    if (eeWriteStrobe)
      mem[eeIndex] <= eeWriteWord;
  end
  // inverted outside the read pulse so a sample taken at the wrong cycle shows
  assign eeReadWord = eeReadStrobe ? mem[eeIndex] : ~mem[eeIndex];
endmodule // ee_table_model

// *** tb/config_capability_registers_tb_top.sv ***
`timescale 1ns/100ps
module config_capability_registers_tb_top;
  // ----------------------------------------------------------------
  // stimulus, table of register cases and directed tests
  // ----------------------------------------------------------------
  typedef struct {logic [7:0] a; logic [31:0] rv, wd, ev; logic er;} row_t;
  logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, eeReadWord, eeWriteWord, rdv;
  logic autoloadValid, eeWriteStrobe, eeReadStrobe, legacyIrqIn, legacyIrqOut;
  logic msgIrqEnable, replayOverride, erv;
  logic [12:0] autoloadReplay;
  logic [4:0] eeIndex;
  logic [63:0] msgIrqAddress;
  logic [15:0] msgIrqData;
  logic [11:0] replayValue;
  int errCount = 0;
  int testsRun = 0;
  int cyc = 0;
  logic [23:0] hiAddr = 24'h000000;
  row_t rows [11] = '{
    '{8'h90, 32'h0, 32'hffffffff, 32'hfffffffc, 1'b0},
    '{8'h94, 32'h0, 32'ha5a55a5a, 32'ha5a55a5a, 1'b0},
    '{8'h98, 32'h0, 32'h0000ffff, 32'h0000ffff, 1'b0},
    '{8'h9c, 32'h0000a403, 32'h007e0000, 32'h007ea403, 1'b0},
    '{8'ha0, 32'h0, 32'h0badf00d, 32'h0badf00d, 1'b0},
    '{8'ha4, 32'h0028e009, 32'hffffffff, 32'h0028e009, 1'b0},
    '{8'ha8, 32'h04001060, 32'h12345678, 32'h12345678, 1'b0},
    '{8'hac, 32'h04000271, 32'h9abcdef0, 32'h9abcdef0, 1'b0},
    '{8'hb0, 32'h0, 32'h0000ffff, 32'h00001fff, 1'b0},
    '{8'hb4, 32'h00800000, 32'h00010000, 32'h00810000, 1'b0},
    '{8'hc0, 32'h0, 32'hffffffff, 32'h0, 1'b1}};

  config_capability_registers config_capability_registers_inst (.mclk, .sys_rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .autoloadValid, .autoloadReplay,
    .eeReadWord, .eeWriteWord, .eeIndex, .eeWriteStrobe, .eeReadStrobe, .legacyIrqIn,
    .legacyIrqOut, .msgIrqEnable, .msgIrqAddress, .msgIrqData, .replayOverride, .replayValue);
  ee_table_model ee_table_model_inst (.mclk, .eeIndex, .eeWriteWord, .eeWriteStrobe,
    .eeReadStrobe, .eeReadWord);

  always #2 mclk = ~mclk;

  task automatic tallyAndFinish();
    $display("checks %0d mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      errCount++;
      tallyAndFinish();
    end
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    testsRun++;
    if (seen !== exp)
    begin
      errCount++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // entered just after an edge; the idle edge at the end keeps strobes from being set twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {hiAddr, a};
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic resetCheck();
    foreach (rows[i])
    begin
      rd(rows[i].a);
      chk(64'(rdv), 64'(rows[i].rv));
    end
    chk(64'({msgIrqEnable, replayOverride, replayValue, eeWriteStrobe, eeReadStrobe}), 64'h0);
    $display("test reset values done");
  endtask

  task automatic pdRun(input logic [31:0] ctl);
    apb(1'b1, 8'h9c, ctl);
    rd(8'h9c);
    chk(64'(rdv[16]), 64'h1);
    for (int n = 0; n < 300 && rdv[16] === 1'b1; n++)
      rd(8'h9c);
    chk(64'(rdv[22:16]), 64'({ctl[22:17], 1'b0}));
  endtask

  initial
  begin
    mclk = 1'b0;
    sys_rst = 1'b1;
    {psel, penable, pwrite, autoloadValid, autoloadReplay} = '0;
    paddr = 32'h0;
    pwdata = 32'h0;
    legacyIrqIn = 1'b1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    resetCheck();
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].a, rows[i].wd);
      chk(64'(erv), 64'(rows[i].er));
      rd(rows[i].a);
      chk(64'({erv, rdv}), 64'({rows[i].er, rows[i].ev}));
    end
    $display("test register table done");
    chk(msgIrqAddress, 64'ha5a55a5afffffffc);
    chk(64'({msgIrqData, msgIrqEnable, legacyIrqOut}), 64'h3fffe);
    apb(1'b1, 8'hb4, 32'h0);
    chk(64'({msgIrqEnable, legacyIrqOut}), 64'h1);
    legacyIrqIn <= 1'b0;
    @(posedge mclk);
    chk(64'(legacyIrqOut), 64'h0);
    $display("test interrupt outputs done");
    chk(64'({replayOverride, replayValue}), 64'h1fff);
    autoloadReplay <= 13'h0123;
    autoloadValid <= 1'b1;
    @(posedge mclk);
    autoloadValid <= 1'b0;
    @(posedge mclk);
    chk(64'({replayOverride, replayValue}), 64'h0123);
    rd(8'hb0);
    chk(64'(rdv), 64'h0123);
    hiAddr = 24'h000001;
    apb(1'b1, 8'hb0, 32'h0000ffff);
    hiAddr = 24'h000000;
    chk(64'(erv), 64'h1);
    rd(8'hb0);
    chk(64'(rdv), 64'h0123);
    $display("test replay autoload done");
    pdRun(32'h00150000);
    rd(8'ha0);
    chk(64'(rdv), 64'ha5c30005);
    apb(1'b1, 8'ha0, 32'h13579bdf);
    pdRun(32'h00270000);
    chk(64'(eeIndex), 64'h9);
    apb(1'b1, 8'ha0, 32'h0);
    pdRun(32'h00250000);
    rd(8'ha0);
    chk(64'(rdv), 64'h13579bdf);
    $display("test product data transfers done");
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    resetCheck();
    tallyAndFinish();
  end
endmodule // config_capability_registers_tb_top
